// ### design/sfrpd_pkg.sv
// sfr page decoder package: addresses, pages, select codes and bus carriers
package sfrpd_pkg;

    // ************************************************************
    // address space and pages
    // ************************************************************
    localparam logic [7:0] SFR_BASE         = 8'h80;
    localparam logic [7:0] SFR_TOP          = 8'hFF;
    localparam logic [7:0] PAGE_ZERO        = 8'h00;
    localparam logic [7:0] PAGE_F           = 8'h0F;
    localparam logic [7:0] PAGE_SEL_RESET   = 8'h00;
    localparam logic [2:0] BIT_ADDR_COLUMN  = 3'h0;

    // ************************************************************
    // decoded addresses
    // ************************************************************
    localparam logic [7:0] ADDR_PAGE_SELECT = 8'hA7;
    localparam logic [7:0] ADDR_CONV_BA     = 8'hBA;
    localparam logic [7:0] ADDR_CONV_BD     = 8'hBD;
    localparam logic [7:0] ADDR_DCDC_96     = 8'h96;

    // ************************************************************
    // one-hot target selects and the all-zero SEL_NONE
    // ************************************************************
    localparam int SEL_W = 7;
    localparam logic [SEL_W-1:0] SEL_NONE     = 7'h00;
    localparam logic [SEL_W-1:0] SEL_PAGE     = 7'h01;
    localparam logic [SEL_W-1:0] SEL_ACC_CFG  = 7'h02;
    localparam logic [SEL_W-1:0] SEL_PWRUP    = 7'h04;
    localparam logic [SEL_W-1:0] SEL_RES_LOW  = 7'h08;
    localparam logic [SEL_W-1:0] SEL_TRACK    = 7'h10;
    localparam logic [SEL_W-1:0] SEL_CHKAUTO  = 7'h20;
    localparam logic [SEL_W-1:0] SEL_DCDC     = 7'h40;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       bit_op;
        logic [2:0] bit_idx;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfrpd_req_t;

    typedef struct packed {
        logic [7:0] dcdc_configuration;
        logic [7:0] checksum_auto_control;
        logic [7:0] converter_tracking_control;
        logic [7:0] converter_result_low;
        logic [7:0] converter_burst_powerup_time;
        logic [7:0] converter_accumulator_config;
    } sfrpd_regs_t;

endpackage : sfrpd_pkg

// ### design/sfrpd_decode.sv
// sfr page decoder address map: address plus page to one-hot target
`timescale 1ns/1ps
module sfrpd_decode
    import sfrpd_pkg::*;
(
    // access
    input  wire logic [7:0]       addr,
    input  wire logic [7:0]       page,
    // result
    output logic      [SEL_W-1:0] sel
);

    always_comb begin
        sel = SEL_NONE;
        if (addr >= SFR_BASE) begin
            if (addr == ADDR_PAGE_SELECT) begin
                sel = SEL_PAGE;
            end else if (page == PAGE_F) begin
                case (addr)
                    ADDR_CONV_BA: sel = SEL_PWRUP;
                    ADDR_CONV_BD: sel = SEL_TRACK;
                    ADDR_DCDC_96: sel = SEL_CHKAUTO;
                    default:      sel = SEL_NONE;
                endcase
            end else if (page == PAGE_ZERO) begin
                case (addr)
                    ADDR_CONV_BA: sel = SEL_ACC_CFG;
                    ADDR_CONV_BD: sel = SEL_RES_LOW;
                    ADDR_DCDC_96: sel = SEL_DCDC;
                    default:      sel = SEL_NONE;
                endcase
            end
        end
    end

endmodule : sfrpd_decode

// ### design/sfrpd_top.sv
// sfr page decoder top: page select register, paged register bank, read mux
`timescale 1ns/1ps
module sfrpd_top
    import sfrpd_pkg::*;
(
    // clock and reset
    input  wire logic              MCLK,
    input  wire logic              RST,
    // cpu access
    input  wire logic              RD,
    input  wire logic              WR,
    input  wire logic              BIT_OP,
    input  wire logic [2:0]        BIT_IDX,
    input  wire logic [7:0]        ADDR,
    input  wire logic [7:0]        WDATA,
    // read answer
    output logic      [7:0]        RDATA,
    output logic                   RVALID,
    // register contents to peripherals
    output logic      [7:0]        PAGE_SELECT,
    output sfrpd_regs_t            REGS,
    // converter result from the converter
    input  wire logic [7:0]        CONV_RESULT_LOW,
    input  wire logic              CONV_RESULT_LD
);

    // ************************************************************
    // request and decode
    // ************************************************************
    sfrpd_req_t       req;
    logic [SEL_W-1:0] sel;
    logic [7:0]       page_ff;
    logic [7:0]       nxt_page;
    sfrpd_regs_t      regs_ff;
    sfrpd_regs_t      nxt_regs;
    logic [7:0]       rdata_ff;
    logic [7:0]       nxt_rdata;
    logic             rvalid_ff;
    logic             nxt_rvalid;
    logic [7:0]       cur;
    logic [7:0]       wval;
    logic             bit_ok;

    assign req = '{rd: RD, wr: WR, bit_op: BIT_OP, bit_idx: BIT_IDX, addr: ADDR, wdata: WDATA};

    sfrpd_decode u_decode (
        .addr (req.addr),
        .page (page_ff),
        .sel  (sel)
    );

    function automatic logic [7:0] pick(input logic [SEL_W-1:0] s, input logic [7:0] pg,
                                        input sfrpd_regs_t r);
        logic [7:0] v;
        v = 8'h00;
        case (s)
            SEL_PAGE:    v = pg;
            SEL_ACC_CFG: v = r.converter_accumulator_config;
            SEL_PWRUP:   v = r.converter_burst_powerup_time;
            SEL_RES_LOW: v = r.converter_result_low;
            SEL_TRACK:   v = r.converter_tracking_control;
            SEL_CHKAUTO: v = r.checksum_auto_control;
            SEL_DCDC:    v = r.dcdc_configuration;
            default:     v = 8'h00;
        endcase
        return v;
    endfunction : pick

    // ************************************************************
    // write and read path
    // ************************************************************
    always_comb begin
        cur      = pick(sel, page_ff, regs_ff);
        bit_ok   = (req.addr[2:0] == BIT_ADDR_COLUMN);
        wval     = req.wdata;
        if (req.bit_op) begin
            wval = cur;
            wval[req.bit_idx] = req.wdata[0];
        end
        nxt_page = page_ff;
        nxt_regs = regs_ff;
        if (CONV_RESULT_LD) begin
            nxt_regs.converter_result_low = CONV_RESULT_LOW;
        end
        if (req.wr && (!req.bit_op || bit_ok)) begin
            case (sel)
                SEL_PAGE:    nxt_page = wval;
                SEL_ACC_CFG: nxt_regs.converter_accumulator_config = wval;
                SEL_PWRUP:   nxt_regs.converter_burst_powerup_time = wval;
                SEL_RES_LOW: nxt_regs.converter_result_low = wval;
                SEL_TRACK:   nxt_regs.converter_tracking_control = wval;
                SEL_CHKAUTO: nxt_regs.checksum_auto_control = wval;
                SEL_DCDC:    nxt_regs.dcdc_configuration = wval;
                default:     nxt_page = page_ff;
            endcase
        end
        nxt_rvalid = req.rd;
        nxt_rdata  = 8'h00;
        if (req.rd) begin
            if (req.bit_op) begin
                nxt_rdata = bit_ok ? {7'h00, cur[req.bit_idx]} : 8'h00;
            end else begin
                nxt_rdata = cur;
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge MCLK) begin
        if (RST) begin
            page_ff   <= PAGE_SEL_RESET;
            regs_ff   <= '0;
            rdata_ff  <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            page_ff   <= nxt_page;
            regs_ff   <= nxt_regs;
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign RDATA       = rdata_ff;
    assign RVALID      = rvalid_ff;
    assign PAGE_SELECT = page_ff;
    assign REGS        = regs_ff;

endmodule : sfrpd_top

// ### verif/sfrpd_checker.sv
// sfr page decoder checker: port-level assertions and bind
`timescale 1ns/1ps
module sfrpd_checker
    import sfrpd_pkg::*;
(
    // clock and reset
    input wire logic        MCLK,
    input wire logic        RST,
    // cpu access
    input wire logic        RD,
    input wire logic        WR,
    input wire logic        BIT_OP,
    input wire logic [7:0]  ADDR,
    input wire logic [7:0]  WDATA,
    // answers
    input wire logic [7:0]  RDATA,
    input wire logic        RVALID,
    input wire logic [7:0]  PAGE_SELECT,
    input sfrpd_regs_t      REGS
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    sequence s_pg_wr; WR && !BIT_OP && ADDR == ADDR_PAGE_SELECT; endsequence
    sequence s_pg_rd; RD && !BIT_OP && ADDR == ADDR_PAGE_SELECT; endsequence
    property p_rvalid; RD |=> RVALID; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    property p_idle; !RD |=> !RVALID && RDATA == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("answer without read");
    property p_pg_wr; s_pg_wr |=> PAGE_SELECT == $past(WDATA); endproperty
    a_pg_wr: assert property (p_pg_wr) else $error("page write lost");
    property p_pg_hold; !(WR && ADDR == ADDR_PAGE_SELECT) |=> $stable(PAGE_SELECT); endproperty
    a_pg_hold: assert property (p_pg_hold) else $error("page changed by itself");
    property p_pg_rd; s_pg_rd |=> RDATA == $past(PAGE_SELECT); endproperty
    a_pg_rd: assert property (p_pg_rd) else $error("page read wrong");
    property p_low; RD && ADDR < SFR_BASE |=> RDATA == 8'h00; endproperty
    a_low: assert property (p_low) else $error("low address answered");
    property p_acc; WR && !BIT_OP && ADDR == ADDR_CONV_BA && PAGE_SELECT == PAGE_ZERO
        |=> REGS.converter_accumulator_config == $past(WDATA); endproperty
    a_acc: assert property (p_acc) else $error("page 0 write at BA lost");
    property p_pwr; WR && !BIT_OP && ADDR == ADDR_CONV_BA && PAGE_SELECT == PAGE_F
        |=> REGS.converter_burst_powerup_time == $past(WDATA); endproperty
    a_pwr: assert property (p_pwr) else $error("page F write at BA lost");
    property p_unm; RD && PAGE_SELECT == PAGE_F && ADDR == 8'h97 |=> RDATA == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule : sfrpd_checker

bind sfrpd_top sfrpd_checker sfrpd_checker_i (.MCLK(MCLK), .RST(RST), .RD(RD), .WR(WR),
    .BIT_OP(BIT_OP), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .RVALID(RVALID),
    .PAGE_SELECT(PAGE_SELECT), .REGS(REGS));

// ### verif/sfrpd_conv_model.sv
// converter model: loads a result low byte on command
`timescale 1ns/1ps
module sfrpd_conv_model (
    // control
    input  wire logic       mclk,
    input  wire logic       go,
    input  wire logic [7:0] val,
    // result to decoder
    output logic      [7:0] result_low,
    output logic            result_ld
);
    initial begin
        result_low = 8'h00;
        result_ld  = 1'b0;
    end
    // outside a load the byte is inverted each cycle, so a stale value matches only every second cycle
    always @(posedge mclk) begin
        result_ld  <= go;
        result_low <= go ? val : ~result_low;
    end
endmodule : sfrpd_conv_model

// ### verif/testbench.sv
// sfr page decoder testbench: paged register access tests
`timescale 1ns/1ps
module testbench;
    import sfrpd_pkg::*;
    logic MCLK = 1'b0, RST = 1'b1, RD = 1'b0, WR = 1'b0, go = 1'b0, rvalid, ld;
    logic bop = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, val = 8'h00, rdata, page, res_low;
    sfrpd_regs_t regs;
    int n_errors = 0;
    int samples_checked = 0;
    always #4 MCLK = ~MCLK;
    sfrpd_conv_model sfrpd_conv_model_i (.mclk(MCLK), .go(go), .val(val),
        .result_low(res_low), .result_ld(ld));
    sfrpd_top sfrpd_top_i (.MCLK(MCLK), .RST(RST), .RD(RD), .WR(WR), .BIT_OP(bop),
        .BIT_IDX(3'h2), .ADDR(addr), .WDATA(wdata), .RDATA(rdata), .RVALID(rvalid),
        .PAGE_SELECT(page), .REGS(regs), .CONV_RESULT_LOW(res_low), .CONV_RESULT_LD(ld));
    task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a; wdata = d; WR = 1'b1;
        @(negedge MCLK) WR = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        addr = a; RD = 1'b1;
        @(negedge MCLK) RD = 1'b0;
        chk("rvalid", rvalid, 1'b1);
        chk("rdata", rdata, exp);
    endtask : rd
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    initial begin
        #5000 n_errors++;
        stop_test();
    end
    initial begin
        repeat (2) @(negedge MCLK);
        RST = 1'b0;
        chk("reset page", page, PAGE_SEL_RESET);
        chk("reset regs", regs, 48'h0);
        rd(ADDR_PAGE_SELECT, 8'h00);
        $display("test reset done");
        wr(ADDR_CONV_BA, 8'h11);
        wr(ADDR_CONV_BD, 8'h22);
        wr(ADDR_DCDC_96, 8'h33);
        rd(ADDR_CONV_BA, 8'h11);
        rd(8'h3A, 8'h00);
        chk("page 0 regs", regs, 48'h33_00_00_22_00_11);
        bop = 1'b1;
        wr(ADDR_CONV_BA, 8'h01);
        rd(ADDR_CONV_BA, 8'h00);
        bop = 1'b0;
        rd(ADDR_CONV_BA, 8'h11);
        $display("test page 0 done");
        wr(ADDR_PAGE_SELECT, PAGE_F);
        rd(ADDR_PAGE_SELECT, PAGE_F);
        wr(ADDR_CONV_BA, 8'h44);
        wr(ADDR_CONV_BD, 8'h55);
        wr(ADDR_DCDC_96, 8'h66);
        wr(8'h97, 8'h77);
        rd(8'h97, 8'h00);
        rd(ADDR_CONV_BD, 8'h55);
        rd(ADDR_DCDC_96, 8'h66);
        chk("page F regs", regs, 48'h33_66_55_22_44_11);
        $display("test page F done");
        wr(ADDR_PAGE_SELECT, PAGE_ZERO);
        rd(ADDR_CONV_BA, 8'h11);
        rd(ADDR_DCDC_96, 8'h33);
        go = 1'b1; val = 8'h5A;
        @(negedge MCLK) go = 1'b0;
        repeat (2) @(negedge MCLK);
        rd(ADDR_CONV_BD, 8'h5A);
        $display("test back to page 0 done");
        stop_test();
    end
endmodule : testbench
